// >>> src/fsac_pkg.sv
// Package for the flash sector access control block: map, fields, codes
package fsac_pkg;
    // Register byte addresses; the control register keeps its printed index
    localparam logic [7:0]  FSAC_CTRL_IDX   = 8'h29;
    localparam logic [9:0]  FSAC_CTRL_ADDR  = {FSAC_CTRL_IDX, 2'b00};
    localparam logic [9:0]  FSAC_KEY_ADDR   = 10'h000;
    localparam logic [9:0]  FSAC_FADDR_ADDR = 10'h004;
    localparam logic [9:0]  FSAC_FDATA_ADDR = 10'h008;
    localparam logic [9:0]  FSAC_OPT_ADDR   = 10'h00C;
    localparam logic [9:0]  FSAC_STAT_ADDR  = 10'h010;
    localparam logic [9:0]  FSAC_LINK_ADDR  = 10'h014;
    localparam logic [7:0]  FSAC_CTRL_RST   = 8'h00;
    // Control bits
    localparam int FSAC_C_PROG  = 0;
    localparam int FSAC_C_SERA  = 1;
    localparam int FSAC_C_MERA  = 2;
    localparam int FSAC_C_OPT   = 3;
    // Unlock key pair
    localparam logic [7:0]  FSAC_KEY1 = 8'hA5;
    localparam logic [7:0]  FSAC_KEY2 = 8'h5A;
    // Array size in Kbytes and sector layout
    localparam int          FSAC_FLASH_KB = 60;
    localparam logic [16:0] FSAC_ARRAY_LO = 17'h10000 - 17'(FSAC_FLASH_KB * 1024);
    localparam logic [15:0] FSAC_SEC0_LO  = 16'hF000;
    localparam logic [15:0] FSAC_SEC1_LO  = 16'hE000;
    localparam logic [1:0]  FSAC_NSEC     = (FSAC_FLASH_KB <= 4) ? 2'd1 :
                                            (FSAC_FLASH_KB <= 8) ? 2'd2 : 2'd3;
    // AXI responses
    localparam logic [1:0]  FSAC_OKAY   = 2'b00;
    localparam logic [1:0]  FSAC_SLVERR = 2'b10;
    localparam int          FSAC_LINK_BITS = 8;
    // Operations handed to the array macro
    typedef enum logic [2:0] {
        FSAC_OP_NONE, FSAC_OP_PROG, FSAC_OP_SECT, FSAC_OP_MASS, FSAC_OP_OPT
    } fsac_op_t;
    typedef enum logic [1:0] {
        FSAC_ST_IDLE, FSAC_ST_RUN, FSAC_ST_WIPE
    } fsac_state_t;
endpackage : fsac_pkg

// >>> src/flash_sector_access_control.sv
// Flash sector access control: AXI4-Lite registers, sector guard, link
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RQ1 - Mass erase, sector erase, byte program
// RQ2 - Sector erase names only its own sector
// RQ3 - Tool and in-circuit modes unlock all sectors, mass erase and option write; readout protection stays
// RQ4 - Application mode refuses vector sector writes
// RQ5 - Sector count follows array size
// RQ6 - 4K sectors at top, vector F000-FFFF
// RQ7 - Protection blocks all external readout
// RQ8 - Unprotecting forces full erase first
// RQ9 - One option bit holds protection
// RQ10 - Tool enters in-circuit mode first
// RQ11 - Tool alone drives reset in session; no reset control here, aresetn is only an input
// RQ12 - Link pins reserved once tool attached
// RQ13 - Control register index 29h, resets 00h
// RQ14 - Guard against accidental program/erase
// RQ15 - Key pair unlocks, relock after operation
module flash_sector_access_control
    import fsac_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [9:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [9:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               tool_socket_mode,
    input  wire logic               programming_voltage_select,
    input  wire logic               tool_attached,
    input  wire logic               option_readout_strap,
    input  wire logic               debug_link_clock,
    input  wire logic               debug_link_data_i,
    output logic                    debug_link_data_o,
    output logic                    debug_link_data_oe,
    output logic                    link_pins_reserved,
    output logic                    readout_block,
    output fsac_pkg::fsac_op_t      flash_op,
    output logic [15:0]             flash_addr,
    output logic [7:0]              flash_wdata,
    output logic                    flash_opt_value,
    input  wire logic               flash_done,
    input  wire logic [7:0]         flash_rdata
);
    import fsac_pkg::*;

    typedef struct packed {
        logic [4:0]  sync1;
        logic [4:0]  sync2;
        logic        lclk_q, aw_got, w_got, awready, wready, bvalid, arready, rvalid;
        logic [9:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [1:0]  bresp;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  ctrl;
        logic [1:0]  key_step;
        logic        unlocked, opt_req, protect, strap_done, refused;
        logic [15:0] faddr;
        logic [7:0]  fdata;
        fsac_state_t state;
        fsac_op_t    op;
        logic [7:0]  shift;
        logic [2:0]  bitcnt;
        logic        reply, dout, doe;
        logic [7:0]  link_rx;
    } fsac_regs_t;

    fsac_regs_t r;
    fsac_regs_t nxt;
    // Synchronised pins, second stage only
    logic s_tool, s_icc, s_att, s_lclk, s_ldat;
    assign {s_tool, s_icc, s_att, s_lclk, s_ldat} = r.sync2;
    // Sector decode; sectors beyond the fitted count are outside the array
    logic       in_array, all_access, allowed, wr_now;
    logic [1:0] sector;
    logic [9:0] wa;
    always_comb
    begin
        sector     = (r.faddr >= FSAC_SEC0_LO) ? 2'd0 :                  // [RQ6]
                     (r.faddr >= FSAC_SEC1_LO) ? 2'd1 : 2'd2;
        in_array   = ({1'b0, r.faddr} >= FSAC_ARRAY_LO) && (sector < FSAC_NSEC); // [RQ5]
        all_access = s_tool | s_icc;                       // [RQ3]
        allowed    = in_array & (all_access | (sector != 2'd0)); // [RQ4]
        wr_now     = r.aw_got & r.w_got & ~r.bvalid;
        wa         = r.awaddr;
    end
    // Next-state logic for bus, guard, sequencer and link
    always_comb
    begin
        nxt         = r;
        nxt.sync1   = {tool_socket_mode, programming_voltage_select, tool_attached,
                       debug_link_clock, debug_link_data_i};
        nxt.sync2   = r.sync1;
        nxt.lclk_q  = s_lclk;
        // Strap caught on the first clock after reset release
        if (!r.strap_done)
        begin
            nxt.protect    = option_readout_strap;         // [RQ9]
            nxt.strap_done = 1'b1;
        end

        // Address and data accepted in either order
        if (s_axi_awvalid && r.awready)
        begin
            nxt.aw_got  = 1'b1;
            nxt.awaddr  = s_axi_awaddr;
            nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && r.wready)
        begin
            nxt.w_got = 1'b1;
            nxt.wdata = s_axi_wdata;
            nxt.wstrb = s_axi_wstrb;
            nxt.wready = 1'b0;
        end
        if (r.bvalid && s_axi_bready)
        begin
            nxt.bvalid  = 1'b0;
            nxt.awready = 1'b1;
            nxt.wready  = 1'b1;
        end

        // Register write; the key register arms the control register
        if (wr_now)
        begin
            nxt.aw_got = 1'b0;
            nxt.w_got  = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp  = FSAC_OKAY;
            if (r.wstrb[0])
            begin
                case (wa)
                    FSAC_KEY_ADDR:
                    begin
                        // Any wrong byte restarts the pair [RQ14]
                        nxt.key_step = 2'd0;
                        if (r.key_step == 2'd0 && r.wdata[7:0] == FSAC_KEY1)
                            nxt.key_step = 2'd1;
                        if (r.key_step == 2'd1 && r.wdata[7:0] == FSAC_KEY2)
                            nxt.unlocked = 1'b1;           // [RQ15]
                    end
                    FSAC_FADDR_ADDR: nxt.faddr[7:0] = r.wdata[7:0];
                    FSAC_FDATA_ADDR: nxt.fdata      = r.wdata[7:0];
                    FSAC_OPT_ADDR:   nxt.opt_req    = r.wdata[0];
                    FSAC_CTRL_ADDR:
                    begin
                        // Locked or busy: the write is dropped silently [RQ15]
                        if (r.unlocked && r.state == FSAC_ST_IDLE)
                            nxt.ctrl = r.wdata[7:0];       // [RQ13]
                    end
                    FSAC_STAT_ADDR, FSAC_LINK_ADDR: ;
                    default: nxt.bresp = FSAC_SLVERR;
                endcase
            end
            if (r.wstrb[1] && wa == FSAC_FADDR_ADDR)
                nxt.faddr[15:8] = r.wdata[15:8];
            if (wa > FSAC_LINK_ADDR && wa != FSAC_CTRL_ADDR)
                nxt.bresp = FSAC_SLVERR;
        end

        // Register read, one cycle after the address is taken
        if (s_axi_arvalid && r.arready)
        begin
            nxt.arready = 1'b0;
            nxt.rvalid  = 1'b1;
            nxt.rresp   = FSAC_OKAY;
            nxt.rdata   = '0;
            case (s_axi_araddr)
                FSAC_KEY_ADDR:   nxt.rdata = '0;
                FSAC_FADDR_ADDR: nxt.rdata[15:0] = r.faddr;
                FSAC_FDATA_ADDR: nxt.rdata[7:0]  = r.fdata;
                FSAC_OPT_ADDR:   nxt.rdata[0]    = r.opt_req;
                FSAC_CTRL_ADDR:  nxt.rdata[7:0]  = r.ctrl;
                FSAC_STAT_ADDR:  nxt.rdata[10:0] = {FSAC_NSEC, s_att, s_icc, s_tool,
                                                    r.protect, r.refused, r.unlocked,
                                                    r.state != FSAC_ST_IDLE,
                                                    r.key_step};
                FSAC_LINK_ADDR:  nxt.rdata[7:0]  = r.link_rx;
                default:         nxt.rresp = FSAC_SLVERR;
            endcase
        end
        if (r.rvalid && s_axi_rready)
        begin
            nxt.rvalid  = 1'b0;
            nxt.arready = 1'b1;
        end

        // Operation sequencer; control bits are cleared when taken
        case (r.state)
            FSAC_ST_IDLE:
            begin
                if (r.ctrl != FSAC_CTRL_RST)
                begin
                    nxt.ctrl     = FSAC_CTRL_RST;
                    nxt.unlocked = 1'b0;                   // [RQ15]
                    nxt.refused  = 1'b0;
                    nxt.state    = FSAC_ST_RUN;
                    if (r.ctrl[FSAC_C_OPT])
                    begin
                        if (!all_access)
                        begin
                            nxt.refused = 1'b1;            // [RQ3]
                            nxt.state   = FSAC_ST_IDLE;
                        end
                        else if (r.protect && !r.opt_req)
                        begin
                            nxt.op    = FSAC_OP_MASS;      // [RQ8]
                            nxt.state = FSAC_ST_WIPE;
                        end
                        else
                            nxt.op = FSAC_OP_OPT;          // [RQ9]
                    end
                    else if (r.ctrl[FSAC_C_MERA])
                    begin
                        if (all_access)
                            nxt.op = FSAC_OP_MASS;         // [RQ1]
                        else
                        begin
                            nxt.refused = 1'b1;            // [RQ4]
                            nxt.state   = FSAC_ST_IDLE;
                        end
                    end
                    else if (!allowed)
                    begin
                        nxt.refused = 1'b1;                // [RQ4]
                        nxt.state   = FSAC_ST_IDLE;
                    end
                    else if (r.ctrl[FSAC_C_SERA])
                        nxt.op = FSAC_OP_SECT;             // [RQ2]
                    else if (r.ctrl[FSAC_C_PROG])
                        nxt.op = FSAC_OP_PROG;             // [RQ1]
                    else
                        nxt.state = FSAC_ST_IDLE;
                end
            end
            FSAC_ST_WIPE:
            begin
                // Option changes only after the array is blank [RQ8]
                if (flash_done)
                    nxt.op = FSAC_OP_OPT;
                if (flash_done)
                    nxt.state = FSAC_ST_RUN;
            end
            FSAC_ST_RUN:
            begin
                if (flash_done)
                begin
                    if (r.op == FSAC_OP_OPT)
                        nxt.protect = r.opt_req;           // [RQ9]
                    nxt.op    = FSAC_OP_NONE;
                    nxt.state = FSAC_ST_IDLE;
                end
            end
            default: nxt.state = FSAC_ST_IDLE;
        endcase

        // Link: sample on rising, drive on falling edge of the tool clock
        if (!s_att || !s_icc)
        begin
            nxt.bitcnt = '0;
            nxt.reply  = 1'b0;
            nxt.doe    = 1'b0;
        end
        else if (s_lclk && !r.lclk_q)
        begin
            nxt.shift  = {r.shift[6:0], s_ldat & ~r.reply};  // Zeros shift in while replying
            nxt.bitcnt = r.bitcnt + 3'd1;
            if (r.bitcnt == 3'(FSAC_LINK_BITS - 1))
            begin
                nxt.reply = ~r.reply;
                if (!r.reply)
                begin
                    nxt.link_rx = {r.shift[6:0], s_ldat};
                    // Protected array answers zeros [RQ7]
                    nxt.shift   = r.protect ? 8'h00 : flash_rdata;
                end
            end
        end
        else if (!s_lclk && r.lclk_q)
        begin
            nxt.dout = r.shift[7];
            nxt.doe  = r.reply & ~r.protect;               // [RQ7]
        end
    end

    // Single state register, synchronous active-low reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r         <= '0;                               // Idle state, no op
            r.awready <= 1'b1;
            r.wready  <= 1'b1;
            r.arready <= 1'b1;
            r.protect <= 1'b1;                             // Safe until strap is read
        end
        else
            r <= nxt;
    end

    assign s_axi_awready      = r.awready;
    assign s_axi_wready       = r.wready;
    assign s_axi_bvalid       = r.bvalid;
    assign s_axi_bresp        = r.bresp;
    assign s_axi_arready      = r.arready;
    assign s_axi_rvalid       = r.rvalid;
    assign s_axi_rdata        = r.rdata;
    assign s_axi_rresp        = r.rresp;
    assign debug_link_data_o  = r.dout;
    assign debug_link_data_oe = r.doe;
    assign link_pins_reserved = r.sync2[2];                // [RQ12]
    assign readout_block      = r.protect;                 // [RQ7]
    assign flash_op           = r.op;
    assign flash_addr         = r.faddr;
    assign flash_wdata        = r.fdata;
    assign flash_opt_value    = r.opt_req;
endmodule : flash_sector_access_control

`default_nettype wire

// >>> tb/fsac_monitor.sv
// Checker for the flash sector access control ports
`timescale 1ns/10ps
`default_nettype none
module fsac_monitor
    import fsac_pkg::*;
(
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_bvalid,
    input wire logic               tool_socket_mode,
    input wire logic               programming_voltage_select,
    input wire logic               tool_attached,
    input wire logic               debug_link_data_oe,
    input wire logic               link_pins_reserved,
    input wire logic               readout_block,
    input wire fsac_pkg::fsac_op_t flash_op,
    input wire logic [15:0]        flash_addr,
    input wire logic               flash_done
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Protection must hold from the first edge out of reset
    AST_RST_PROT: assert property ($rose(aresetn) |-> readout_block)
        else $error("readout not blocked after reset");
    AST_OE_PROT: assert property (readout_block && $past(readout_block)
        |-> !debug_link_data_oe)
        else $error("link driven while protected");
    // Whole-array and option work only from tool or in-circuit mode
    AST_PRIV_OP: assert property (flash_op inside {FSAC_OP_MASS, FSAC_OP_OPT}
        |-> tool_socket_mode || programming_voltage_select)
        else $error("privileged op in application mode");
    AST_VEC_GUARD: assert property (flash_op inside {FSAC_OP_PROG, FSAC_OP_SECT}
        && flash_addr >= FSAC_SEC0_LO
        |-> tool_socket_mode || programming_voltage_select)
        else $error("vector sector written in application mode");
    AST_OP_HOLD: assert property (flash_op != FSAC_OP_NONE && !flash_done
        |=> $stable(flash_op) && $stable(flash_addr))
        else $error("op changed before done");
    // Only a protection wipe chains a second op onto the done pulse
    AST_OP_END: assert property (flash_op != FSAC_OP_NONE && flash_op != FSAC_OP_MASS
        && flash_done |=> flash_op == FSAC_OP_NONE)
        else $error("op not cleared after done");
    AST_WIPE_NEXT: assert property (flash_op == FSAC_OP_MASS && flash_done
        |=> flash_op inside {FSAC_OP_NONE, FSAC_OP_OPT})
        else $error("mass erase not followed by idle or option write");
    // Two-stage sync chain, read straight from its second stage, allows a short lag
    AST_PIN_ON: assert property ($rose(tool_attached)
        |-> ##[1:4] link_pins_reserved)
        else $error("pins not reserved on attach");
    AST_PIN_OFF: assert property ($fell(tool_attached)
        |-> ##[1:4] !link_pins_reserved)
        else $error("pins still reserved after detach");
    AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write accepted during response");
endmodule : fsac_monitor
`default_nettype wire

// >>> tb/fsac_tool_model.sv
// Programming tool stand-in on the two-pin serial link
`timescale 1ns/10ps
`default_nettype none
module fsac_tool_model
(
    input  wire logic aclk,
    input  wire logic dev_o,
    input  wire logic dev_oe,
    output var  logic attached,
    output var  logic vsel,
    output var  logic lclk,
    output wire logic ldata
);
    logic drv_r = 1'h0;
    logic bit_r = 1'h0;
    logic tog_r = 1'h0;
    initial
    begin
        attached = 1'h0;
        vsel = 1'h0;
        lclk = 1'h0;
    end
    // Released line toggles so a stale bit never looks valid
    assign ldata = dev_oe ? dev_o : (drv_r ? bit_r : tog_r);
    always @(posedge aclk) tog_r <= ~tog_r;
    // Plug in and select in-circuit mode before any frame
    task attach(input logic a, input logic v);
        attached <= a;
        vsel <= v;
    endtask : attach
    // Byte out MSB first, then reply in; clock idles low between frames
    task frame(input logic [7:0] tx, output logic [7:0] rx, output logic oe_seen);
        rx = 8'h00;
        oe_seen = 1'h0;
        #1.3;
        drv_r = 1'h1;
        for (int i = 7; i >= 0; i--)
        begin
            bit_r = tx[i];
            #32 lclk = 1'h1;
            #32 lclk = 1'h0;
        end
        drv_r = 1'h0;
        for (int i = 7; i >= 0; i--)
        begin
            #31 rx[i] = ldata;
            oe_seen = oe_seen | dev_oe;
            #1 lclk = 1'h1;
            #32 lclk = 1'h0;
        end
    endtask : frame
endmodule : fsac_tool_model
`default_nettype wire

// >>> tb/flash_sector_access_control_tb_top.sv
// Bench: register tasks, array stand-in and access scenarios
`timescale 1ns/10ps
`default_nettype none
module flash_sector_access_control_tb_top;
    import fsac_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, sock, att, vsel;
    logic        lclk, ldat, ld_o, ld_oe, pins, rblk, oe, optv;
    logic        done = 1'h0;
    logic        strap = 1'h0;
    logic [9:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] faddr;
    logic [7:0]  rx, fwd;
    logic [2:0]  cnt = 3'h0;
    fsac_op_t    fop;
    fsac_op_t    olog[$];
    logic [15:0] alog[$];
    int          mismatches, n_tests, cyc;

    flash_sector_access_control dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .tool_socket_mode(sock),
        .programming_voltage_select(vsel), .tool_attached(att),
        .option_readout_strap(strap), .debug_link_clock(lclk),
        .debug_link_data_i(ldat), .debug_link_data_o(ld_o),
        .debug_link_data_oe(ld_oe), .link_pins_reserved(pins),
        .readout_block(rblk), .flash_op(fop), .flash_addr(faddr),
        .flash_wdata(fwd), .flash_opt_value(optv), .flash_done(done),
        .flash_rdata(8'h96));
    fsac_tool_model tool (.aclk(aclk), .dev_o(ld_o), .dev_oe(ld_oe),
        .attached(att), .vsel(vsel), .lclk(lclk), .ldata(ldat));

    initial
    begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    // Array stand-in: finishes an op after four cycles and logs its start, but a chained op waits for the 3-bit count to wrap
    always @(posedge aclk)
    begin
        cnt <= (fop == FSAC_OP_NONE) ? 3'h0 : cnt + 3'h1;
        done <= (fop != FSAC_OP_NONE) && (cnt == 3'h3);
        if (fop != FSAC_OP_NONE && cnt == 3'h0)
        begin
            olog.push_back(fop);
            alog.push_back(faddr);
        end
    end
    // Hang guard, well above the planned run length
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            end_sim();
        end
    end

    task end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Both channels offered together, each dropped once taken
    task wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ga, gw;
        ga = 1'h0;
        gw = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(ga && gw))
        begin
            @(posedge aclk);
            if (awvalid && awready === 1'h1)
            begin
                ga = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready === 1'h1)
            begin
                gw = 1'h1;
                wvalid <= 1'h0;
            end
        end
        while (bvalid !== 1'h1) @(posedge aclk);
        rs = bresp;
        bready <= 1'h0;
    endtask : wr
    task rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge aclk);
        v = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask : rd
    // Load address, optionally unlock, fire control; expect nexp ops
    task do_op(input logic [15:0] a, input logic [7:0] c, input logic unl,
               input int nexp, input fsac_op_t e);
        int n0;
        n0 = olog.size();
        wr(FSAC_FADDR_ADDR, {16'h0000, a}, r);
        if (unl)
        begin
            wr(FSAC_KEY_ADDR, {24'h000000, FSAC_KEY1}, r);
            wr(FSAC_KEY_ADDR, {24'h000000, FSAC_KEY2}, r);
        end
        wr(FSAC_CTRL_ADDR, {24'h000000, c}, r);
        repeat (30) @(posedge aclk);
        chk("op count", 32'(n0 + nexp), 32'(olog.size()));
        if (nexp > 0)
        begin
            chk("op kind", 32'(e), 32'(olog[$]));
            chk("op addr", {16'h0000, a}, {16'h0000, alog[$]});
        end
    endtask : do_op

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, sock} = 6'h00;
        awaddr = 10'h000;
        araddr = 10'h000;
        wdata = 32'h0;
        aresetn = 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(FSAC_CTRL_ADDR, d, r);
        chk("ctrl reset", 32'h0, d);
        rd(10'h3FC, d, r);
        chk("unmapped resp", 32'(FSAC_SLVERR), 32'(r));
        rd(FSAC_STAT_ADDR, d, r);
        chk("sectors", 32'h3, 32'(d[10:9]));
        chk("protect off", 32'h0, 32'(rblk));
        do_op(16'hEFFF, 8'h01, 1'h0, 0, FSAC_OP_NONE);
        wr(FSAC_FDATA_ADDR, 32'hA7, r);
        chk("prog data", 32'hA7, 32'(fwd));
        do_op(16'hEFFF, 8'h01, 1'h1, 1, FSAC_OP_PROG);
        do_op(16'hE000, 8'h01, 1'h0, 0, FSAC_OP_NONE);
        do_op(16'hF000, 8'h02, 1'h1, 0, FSAC_OP_NONE);
        rd(FSAC_STAT_ADDR, d, r);
        chk("refused flag", 32'h1, 32'(d[4]));
        do_op(16'hFFFF, 8'h01, 1'h1, 0, FSAC_OP_NONE);
        do_op(16'h1000, 8'h04, 1'h1, 0, FSAC_OP_NONE);
        do_op(16'hE000, 8'h02, 1'h1, 1, FSAC_OP_SECT);
        sock <= 1'h1;
        do_op(16'hF000, 8'h02, 1'h1, 1, FSAC_OP_SECT);
        do_op(16'h1000, 8'h04, 1'h1, 1, FSAC_OP_MASS);
        sock <= 1'h0;
        tool.attach(1'h1, 1'h1);
        do_op(16'hFFFF, 8'h01, 1'h1, 1, FSAC_OP_PROG);
        tool.frame(8'hC3, rx, oe);
        rd(FSAC_LINK_ADDR, d, r);
        chk("link byte", 32'hC3, d);
        chk("reply", 32'h96, {24'h0, rx});
        chk("reply drive", 32'h1, 32'(oe));
        chk("pins", 32'h1, 32'(pins));
        wr(FSAC_OPT_ADDR, 32'h1, r);
        chk("opt value", 32'h1, 32'(optv));
        do_op(16'h1000, 8'h08, 1'h1, 1, FSAC_OP_OPT);
        chk("protect on", 32'h1, 32'(rblk));
        tool.frame(8'h3C, rx, oe);
        chk("no drive", 32'h0, 32'(oe));
        wr(FSAC_OPT_ADDR, 32'h0, r);
        do_op(16'h1000, 8'h08, 1'h1, 2, FSAC_OP_OPT);
        chk("wipe first", 32'(FSAC_OP_MASS), 32'(olog[$-1]));
        chk("protect off", 32'h0, 32'(rblk));
        tool.attach(1'h0, 1'h0);
        repeat (8) @(posedge aclk);
        chk("pins free", 32'h0, 32'(pins));
        // Second reset with the option bit set: protection must stay on
        strap <= 1'h1;
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        chk("strap protect", 32'h1, 32'(rblk));
        rd(FSAC_CTRL_ADDR, d, r);
        chk("ctrl reset again", 32'h0, d);
        end_sim();
    end
endmodule : flash_sector_access_control_tb_top

bind flash_sector_access_control fsac_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .tool_socket_mode(tool_socket_mode),
    .programming_voltage_select(programming_voltage_select),
    .tool_attached(tool_attached), .debug_link_data_oe(debug_link_data_oe),
    .link_pins_reserved(link_pins_reserved), .readout_block(readout_block),
    .flash_op(flash_op), .flash_addr(flash_addr), .flash_done(flash_done));
`default_nettype wire
